// ==== rtl/fpxm_defs.svh ====
// register map, field positions and reset values of the fp trap/mode block
`ifndef FPXM_DEFS_SVH
`define FPXM_DEFS_SVH
// -----------------------------------------------------------------------
// register byte addresses
// -----------------------------------------------------------------------
`define FPXM_OFF_ENABLES   8'h00
`define FPXM_OFF_STATUS    8'h04
`define FPXM_OFF_TRAPINFO  8'h08
// -----------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------
`define FPXM_EN_HI         11
`define FPXM_EN_LO         7
`define FPXM_FLUSH_BIT     2
`define FPXM_RM_HI         1
`define FPXM_RM_LO         0
`define FPXM_CAUSE_HI      16
`define FPXM_CAUSE_LO      12
`define FPXM_ST_FLUSH_BIT  24
`define FPXM_TI_UNIMPL_BIT 5
`define FPXM_TI_FLAG_BIT   6
// -----------------------------------------------------------------------
// widths and reset values
// -----------------------------------------------------------------------
`define FPXM_COND_W        5
`define FPXM_RM_W          2
`define FPXM_EN_RST        5'h00
`define FPXM_RM_RST        2'h0
`define FPXM_FLUSH_RST     1'h0
`define FPXM_CAUSE_RST     5'h00
`define FPXM_WORD_ZERO     32'h0000_0000
`endif

// ==== rtl/fpxm_flush_sel.sv ====
// operand and tiny-result conditioning from flush control and rounding mode
`timescale 1ns/1ps
`include "fpxm_defs.svh"
module fpxm_flush_sel (
  input  wire logic              flush_en,
  input  wire fpxm_pkg::fpxm_rm_e round_mode,
  input  wire fpxm_pkg::fpxm_op_s op,
  output logic                   zero_operand,
  output logic                   unimpl,
  output logic                   tiny_zero,
  output logic                   tiny_min
);
  // -----------------------------------------------------------------------
  // decisions
  // -----------------------------------------------------------------------
  logic away_from_zero;

  // directed rounding away from zero lands on the smallest normal value
  always_comb begin
    away_from_zero = 1'b0;
    unique case (round_mode)
      fpxm_pkg::FPXM_RM_PLUS:  away_from_zero = !op.res_neg;
      fpxm_pkg::FPXM_RM_MINUS: away_from_zero = op.res_neg;
      fpxm_pkg::FPXM_RM_NEAREST,
      fpxm_pkg::FPXM_RM_ZERO:  away_from_zero = 1'b0;
    endcase
  end

  // denormal operands: flushed when enabled, else unimplemented op
  assign zero_operand = op.valid && flush_en && op.denorm_in;
  assign unimpl       = op.valid && !flush_en && op.denorm_in;
  // tiny results only move when flushing is on
  assign tiny_min  = op.valid && flush_en && op.tiny_res &&
                     away_from_zero;
  assign tiny_zero = op.valid && flush_en && op.tiny_res &&
                     !away_from_zero;
endmodule : fpxm_flush_sel

// ==== rtl/fpxm_pkg.sv ====
// types shared by the fp trap/mode block
package fpxm_pkg;
  // rounding modes in their register encoding
  typedef enum logic [1:0] {
    FPXM_RM_NEAREST = 2'h0,
    FPXM_RM_ZERO    = 2'h1,
    FPXM_RM_PLUS    = 2'h2,
    FPXM_RM_MINUS   = 2'h3
  } fpxm_rm_e;

  // one arithmetic operation reported by the datapath
  typedef struct packed {
    logic       valid;
    logic [4:0] cause;     // invalid, div0, overflow, underflow, inexact
    logic       denorm_in; // an input operand is denormal
    logic       tiny_res;  // the result is tiny
    logic       res_neg;   // sign of the tiny result
  } fpxm_op_s;

  // decisions returned to the datapath
  typedef struct packed {
    logic trap;
    logic unimpl;
    logic zero_operand;
    logic tiny_zero;
    logic tiny_min;
  } fpxm_res_s;
endpackage : fpxm_pkg

// ==== rtl/fpxm_trap_ctl.sv ====
// fp exception enable, flush and rounding control with trap generation
//
// Overview of operation
// - five trap enables sit in register bits 11 down to 7.
// - bit 11 invalid, 10 divide-by-zero, 9 overflow, 8 underflow, 7 inexact.
// - each enable decides whether its condition takes a trap.
// - an arithmetic op traps when an enable and its cause are both set.
// - a status word write leaving enable and cause both set also traps.
// - the flush control is register bit 2.
// - with flush on, denormal operands are replaced by zero.
// - with flush on, tiny results go to zero or smallest normal by mode.
// - with flush off, a denormal operand raises unimplemented operation.
// - bits 1:0 pick nearest, toward zero, toward +inf, toward -inf.
// - bits 31 to 12 read as zero.
// - bits 6 to 3 read as zero.
`timescale 1ns/1ps
`include "fpxm_defs.svh"
module fpxm_trap_ctl #(
  parameter int ADDR_W = 8,
  parameter int COND_W = 5
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               clk_en,
  input  wire logic [ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [31:0]        reg_rdata,
  input  wire fpxm_pkg::fpxm_op_s op_in,
  output fpxm_pkg::fpxm_res_s     op_res,
  output logic                    flush_denormal_ctl,
  output logic      [1:0]         round_select
);
  // -----------------------------------------------------------------------
  // elaboration checks
  // -----------------------------------------------------------------------
  // the datapath struct and field map are fixed at five conditions
  if (COND_W != `FPXM_COND_W) begin : g_bad_cond
    $error("fpxm_trap_ctl: COND_W must be five");
  end
  if (ADDR_W < 4) begin : g_bad_addr
    $error("fpxm_trap_ctl: ADDR_W too small for the map");
  end

  // -----------------------------------------------------------------------
  // functions
  // -----------------------------------------------------------------------
  // any condition whose enable and cause are both set
  function automatic logic trap_hit(input logic [4:0] en,
                                    input logic [4:0] cause);
    trap_hit = |(en & cause);
  endfunction : trap_hit

  // address compare against a byte offset from the map
  function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] off);
    addr_is = (a == ADDR_W'(off));
  endfunction : addr_is

  // -----------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------
  logic [4:0]         enables_r;
  logic [4:0]         enables_nxt;
  logic               flush_r;
  logic               flush_nxt;
  fpxm_pkg::fpxm_rm_e rm_r;
  fpxm_pkg::fpxm_rm_e rm_nxt;
  logic [4:0]         cause_r;
  logic [4:0]         cause_nxt;
  logic [4:0]         trap_cause_r;
  logic               trap_unimpl_r;
  logic               trap_seen_r;
  fpxm_pkg::fpxm_res_s res_r;
  logic [31:0]        rdata_r;

  logic wr_en;
  logic wr_st;
  logic rd_go;
  logic op_go;
  logic op_trap;
  logic st_trap;
  logic zero_op;
  logic unimpl;
  logic tiny_zero;
  logic tiny_min;

  // -----------------------------------------------------------------------
  // bus decode
  // -----------------------------------------------------------------------
  // all strobes and ops are frozen while the clock enable is low
  assign wr_en = clk_en && reg_wr && addr_is(reg_addr, `FPXM_OFF_ENABLES);
  assign wr_st = clk_en && reg_wr && addr_is(reg_addr, `FPXM_OFF_STATUS);
  assign rd_go = clk_en && reg_rd;
  assign op_go = clk_en && op_in.valid;

  // -----------------------------------------------------------------------
  // control fields
  // -----------------------------------------------------------------------
  // both register views write the same enable, flush and mode fields
  always_comb begin
    enables_nxt = enables_r;
    flush_nxt   = flush_r;
    rm_nxt      = rm_r;
    if (wr_en || wr_st) begin
      enables_nxt = reg_wdata[`FPXM_EN_HI:`FPXM_EN_LO];
      rm_nxt = fpxm_pkg::fpxm_rm_e'(
               reg_wdata[`FPXM_RM_HI:`FPXM_RM_LO]);
      flush_nxt = wr_en ? reg_wdata[`FPXM_FLUSH_BIT]
                        : reg_wdata[`FPXM_ST_FLUSH_BIT];
    end
  end

  // field values are undefined to software; we still park them at zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enables_r <= `FPXM_EN_RST;
      flush_r   <= `FPXM_FLUSH_RST;
      rm_r      <= fpxm_pkg::fpxm_rm_e'(`FPXM_RM_RST);
    end else begin
      enables_r <= enables_nxt;
      flush_r   <= flush_nxt;
      rm_r      <= rm_nxt;
    end
  end

  assign flush_denormal_ctl = flush_r;
  assign round_select       = rm_r;

  // -----------------------------------------------------------------------
  // cause bits
  // -----------------------------------------------------------------------
  // an op in the same cycle as a status write wins, so no event is lost
  always_comb begin
    cause_nxt = cause_r;
    if (wr_st) begin
      cause_nxt = reg_wdata[`FPXM_CAUSE_HI:`FPXM_CAUSE_LO];
    end
    if (op_go) begin
      cause_nxt = op_in.cause;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_r <= `FPXM_CAUSE_RST;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  // -----------------------------------------------------------------------
  // conditioning and trap detection
  // -----------------------------------------------------------------------
  fpxm_flush_sel u_flush_sel (
    .flush_en     (flush_r),
    .round_mode   (rm_r),
    .op           (op_in),
    .zero_operand (zero_op),
    .unimpl       (unimpl),
    .tiny_zero    (tiny_zero),
    .tiny_min     (tiny_min)
  );

  // arithmetic traps use the enables in force for that op
  assign op_trap = op_go && trap_hit(enables_r, op_in.cause);
  // a status write checks the enables and causes it leaves behind
  assign st_trap = wr_st && trap_hit(enables_nxt, cause_nxt);

  // one-cycle registered decisions back to the datapath
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_r <= '0;
    end else if (clk_en) begin
      res_r.trap         <= op_trap || st_trap;
      res_r.unimpl       <= op_go && unimpl;
      res_r.zero_operand <= op_go && zero_op;
      res_r.tiny_zero    <= op_go && tiny_zero;
      res_r.tiny_min     <= op_go && tiny_min;
    end
  end

  assign op_res = res_r;

  // -----------------------------------------------------------------------
  // trap record
  // -----------------------------------------------------------------------
  // keeps the causes of the latest trap so a handler can inspect them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trap_cause_r  <= `FPXM_CAUSE_RST;
      trap_unimpl_r <= 1'b0;
      trap_seen_r   <= 1'b0;
    end else if (op_trap || st_trap || (op_go && unimpl)) begin
      trap_cause_r  <= enables_nxt & cause_nxt;
      trap_unimpl_r <= op_go && unimpl;
      trap_seen_r   <= 1'b1;
    end
  end

  // -----------------------------------------------------------------------
  // read path
  // -----------------------------------------------------------------------
  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= `FPXM_WORD_ZERO;
    end else if (clk_en) begin
      rdata_r <= `FPXM_WORD_ZERO;
      if (rd_go && addr_is(reg_addr, `FPXM_OFF_ENABLES)) begin
        rdata_r[`FPXM_EN_HI:`FPXM_EN_LO] <= enables_r;
        rdata_r[`FPXM_FLUSH_BIT]         <= flush_r;
        rdata_r[`FPXM_RM_HI:`FPXM_RM_LO] <= rm_r;
      end
      if (rd_go && addr_is(reg_addr, `FPXM_OFF_STATUS)) begin
        rdata_r[`FPXM_CAUSE_HI:`FPXM_CAUSE_LO] <= cause_r;
        rdata_r[`FPXM_EN_HI:`FPXM_EN_LO]       <= enables_r;
        rdata_r[`FPXM_ST_FLUSH_BIT]            <= flush_r;
        rdata_r[`FPXM_RM_HI:`FPXM_RM_LO]       <= rm_r;
      end
      if (rd_go && addr_is(reg_addr, `FPXM_OFF_TRAPINFO)) begin
        rdata_r[`FPXM_COND_W-1:0]     <= trap_cause_r;
        rdata_r[`FPXM_TI_UNIMPL_BIT]  <= trap_unimpl_r;
        rdata_r[`FPXM_TI_FLAG_BIT]    <= trap_seen_r;
      end
    end
  end

  assign reg_rdata = rdata_r;

  // -----------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // a write of the enable view loads bits 11:7 into the enables register on the next edge
  enable_field_map_a: assert property (
    (wr_en && !wr_st) |=> (enables_r ==
      $past(reg_wdata[`FPXM_EN_HI:`FPXM_EN_LO])))
    else $error("enable field not taken from bits 11:7");

  // the invalid enable alone does not trap on the inexact cause
  invalid_bit_order_a: assert property (
    (op_go && !wr_st && enables_r == 5'h10 && op_in.cause == 5'h01)
      |=> !op_res.trap)
    else $error("inexact cause trapped through invalid enable");

  // without any enable no arithmetic op may trap
  no_enable_quiet_a: assert property (
    (op_go && !wr_st && enables_r == 5'h00) |=> !op_res.trap)
    else $error("trap taken with all enables clear");

  // matched enable and cause on an op trap on the next edge
  op_trap_raise_a: assert property (
    (op_go && |(enables_r & op_in.cause)) |=> op_res.trap)
    else $error("arithmetic trap missing");

  // status write leaving a matched pair traps on the next edge
  status_trap_raise_a: assert property (
    (wr_st && !op_go &&
     |(reg_wdata[`FPXM_EN_HI:`FPXM_EN_LO] &
       reg_wdata[`FPXM_CAUSE_HI:`FPXM_CAUSE_LO])) |=> op_res.trap)
    else $error("status write trap missing");

  // the flush bit is read back at bit 2 in the cycle after the read
  flush_readback_a: assert property (
    (rd_go && addr_is(reg_addr, `FPXM_OFF_ENABLES) && !wr_en && !wr_st)
      |=> reg_rdata[`FPXM_FLUSH_BIT] == flush_r)
    else $error("flush bit misplaced on read");

  // flushing denormal operands never also reports unimplemented
  denorm_flush_path_a: assert property (
    (op_go && op_in.denorm_in)
      |=> (op_res.zero_operand == $past(flush_r)) &&
          (op_res.unimpl == !$past(flush_r)))
    else $error("denormal operand handling wrong");

  // round toward plus infinity sends positive tiny results to smallest normal
  tiny_plus_sel_a: assert property (
    (op_go && flush_r && op_in.tiny_res && !op_in.res_neg &&
     rm_r == fpxm_pkg::FPXM_RM_PLUS) |=> op_res.tiny_min && !op_res.tiny_zero)
    else $error("tiny result not sent to smallest normal");

  // with flush on, round to nearest always flushes tiny results to zero
  tiny_zero_sel_a: assert property (
    (op_go && flush_r && op_in.tiny_res &&
     rm_r == fpxm_pkg::FPXM_RM_NEAREST) |=> op_res.tiny_zero)
    else $error("tiny result not flushed to zero");

  // the mode pins follow the written code on the next edge
  round_mode_out_a: assert property (
    (wr_en && !wr_st) |=> round_select ==
      $past(reg_wdata[`FPXM_RM_HI:`FPXM_RM_LO]))
    else $error("round select does not follow write");

  // unimplemented bits of the enable view read zero
  upper_zero_a: assert property (
    (rd_go && addr_is(reg_addr, `FPXM_OFF_ENABLES))
      |=> reg_rdata[31:12] == 20'h0_0000 && reg_rdata[6:3] == 4'h0)
    else $error("unimplemented bits read non-zero");

  // read data hold only one cycle
  rdata_one_cycle_a: assert property (
    (clk_en && !reg_rd) |=> reg_rdata == `FPXM_WORD_ZERO)
    else $error("read data held past its cycle");

  // the divide-by-zero enable sits one below invalid and traps on its cause
  div0_bit_trap_a: assert property (
    (op_go && !wr_st && enables_r == 5'h08 && op_in.cause == 5'h08)
      |=> op_res.trap)
    else $error("divide-by-zero enable not matched to its cause");

  // a status write loads the cause field that the status view reads back
  status_cause_load_a: assert property (
    (wr_st && !op_go) |=> cause_r ==
      $past(reg_wdata[`FPXM_CAUSE_HI:`FPXM_CAUSE_LO]))
    else $error("status write did not load the cause field");

  // flush off: a denormal operand is reported, never silently zeroed
  unimpl_no_flush_a: assert property (
    (op_go && !flush_r && op_in.denorm_in)
      |=> op_res.unimpl && !op_res.zero_operand)
    else $error("denormal operand with flush off not reported");

  // round toward minus infinity sends negative tiny results to smallest normal
  tiny_minus_sel_a: assert property (
    (op_go && flush_r && op_in.tiny_res && op_in.res_neg &&
     rm_r == fpxm_pkg::FPXM_RM_MINUS)
      |=> op_res.tiny_min && !op_res.tiny_zero)
    else $error("negative tiny result not sent to smallest normal");

  // round toward zero never lifts a tiny result to the smallest normal
  tiny_chop_sel_a: assert property (
    (op_go && flush_r && op_in.tiny_res &&
     rm_r == fpxm_pkg::FPXM_RM_ZERO)
      |=> op_res.tiny_zero && !op_res.tiny_min)
    else $error("tiny result not flushed to zero when chopping");

  // decisions are single-cycle pulses; a stuck pulse would double-count
  res_idle_zero_a: assert property (
    (clk_en && !op_in.valid && !wr_st) |=> op_res == '0)
    else $error("decision pulse outlived its cycle");

  // a low clock enable freezes fields, pulses and read data alike
  frozen_state_a: assert property (
    (!clk_en) |=> $stable(enables_r) && $stable(flush_r) &&
      $stable(rm_r) && $stable(cause_r) && $stable(op_res) &&
      $stable(reg_rdata))
    else $error("state moved while the clock enable was low");
endmodule : fpxm_trap_ctl

// ==== tb/tb.sv ====
// self-checking bench for the fp trap enable and mode control block
`timescale 1ns/1ps
`include "fpxm_defs.svh"
module tb;
  // ---------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------
  logic                ref_clk;
  logic                rst_n;
  logic                clk_en;
  logic [7:0]          reg_addr;
  logic [31:0]         reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [31:0]         reg_rdata;
  fpxm_pkg::fpxm_op_s  op_in;
  fpxm_pkg::fpxm_res_s op_res;
  logic                flush_denormal_ctl;
  logic [1:0]          round_select;
  int                  err_count;
  int                  checks_done;
  int                  cyc;
  logic [4:0]          en;
  logic                fl;
  logic [4:0]          cs;
  logic [31:0]         ti;
  logic [1:0]          rm;
  logic [31:0]         d;

  fpxm_trap_ctl #(.ADDR_W(8), .COND_W(5)) fpxm_trap_ctl_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_in(op_in),
    .op_res(op_res), .flush_denormal_ctl(flush_denormal_ctl),
    .round_select(round_select)
  );

  // 10 mhz clock
  always #50 ref_clk = ~ref_clk;

  // ---------------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // one-cycle write strobe; the edge after it is where the block takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the strobe, zero in the next one
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata, exp);
    @(negedge ref_clk);
    chk(reg_rdata, 32'h0000_0000);
  endtask : rd

  // write the enables view and keep the bench's copy of the fields
  task automatic wr_en(input logic [31:0] v);
    wr(`FPXM_OFF_ENABLES, v);
    en = v[11:7];
    fl = v[2];
    rm = v[1:0];
  endtask : wr_en

  // ---------------------------------------------------------------------
  // expectations
  // ---------------------------------------------------------------------
  function automatic logic [31:0] view();
    return {20'h0_0000, en, 4'h0, fl, rm};
  endfunction : view

  // status word view: flush 24, cause 16:12, enables 11:7, mode 1:0
  function automatic logic [31:0] st_view();
    return {7'h00, fl, 7'h00, cs, en, 5'h00, rm};
  endfunction : st_view

  function automatic logic [4:0] exp_res(input fpxm_pkg::fpxm_op_s o);
    logic mn;
    mn = fl & o.tiny_res & ((rm == 2'h2 & !o.res_neg) |
                            (rm == 2'h3 & o.res_neg));
    return {|(en & o.cause), o.denorm_in & !fl, o.denorm_in & fl,
            fl & o.tiny_res & !mn, mn};
  endfunction : exp_res

  // one operation, result checked in the cycle after it is taken
  task automatic op(input logic [4:0] c, input logic [2:0] f);
    fpxm_pkg::fpxm_op_s o;
    o = {1'b1, c, f};
    @(posedge ref_clk);
    op_in <= o;
    @(posedge ref_clk);
    op_in <= '0;
    @(negedge ref_clk);
    chk({27'h0, op_res}, {27'h0, exp_res(o)});
  endtask : op

  // hang guard: the whole sequence needs well under 5000 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0; rst_n = 1'b0; clk_en = 1'b1; reg_addr = 8'h00;
    reg_wdata = 32'h0; reg_wr = 1'b0; reg_rd = 1'b0; op_in = '0;
    err_count = 0; checks_done = 0; cyc = 0;
    en = 5'h00;
    fl = 1'b0;
    rm = 2'h0;
    cs = 5'h00;
    ti = 32'h0000_0000;
    void'($urandom(32'h6f28));
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    // reset values were chosen as zero
    rd(`FPXM_OFF_ENABLES, 32'h0000_0000);
    // field layout and reserved bits, all-ones and zero first
    for (int i = 0; i < 24; i++) begin
      d = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $urandom();
      wr_en(d);
      rd(`FPXM_OFF_ENABLES, view());
      chk({29'h0, flush_denormal_ctl, round_select}, {29'h0, fl, rm});
    end
    // unmapped address: write lost, read zero
    wr(8'h0c, $urandom());
    rd(8'h0c, 32'h0000_0000);
    rd(`FPXM_OFF_ENABLES, view());
    // each enable against each cause, bit order 11 down to 7
    for (int i = 0; i < 5; i++) begin
      wr_en({20'h0, 5'(1 << i), 7'h00});
      rd(`FPXM_OFF_ENABLES, {20'h0, 5'(1 << i), 7'h00});
      for (int j = 0; j < 5; j++) op(5'(1 << j), 3'h0);
    end
    // every rounding mode with tiny results of both signs
    for (int r = 0; r < 4; r++) begin
      for (int n = 0; n < 2; n++) begin
        wr_en({29'h0, 1'b1, 2'(r)});
        op(5'h00, {2'b01, 1'(n)});
      end
    end
    // denormal operand with flush off then on
    wr_en(32'h0000_0000);
    op(5'h00, 3'b100);
    wr_en(32'h0000_0004);
    op(5'h00, 3'b100);
    // random operations under random settings
    for (int i = 0; i < 40; i++) begin
      wr_en($urandom());
      op(5'($urandom()), 3'($urandom()));
    end
    // status word writes, trap when enable and cause meet
    for (int i = 0; i < 12; i++) begin
      d = (i == 0) ? 32'h0001_0800 : (i == 1) ? 32'h0000_0f80 : $urandom();
      wr(`FPXM_OFF_STATUS, d);
      @(negedge ref_clk);
      chk({31'h0, op_res.trap}, {31'h0, |(d[11:7] & d[16:12])});
      en = d[11:7];
      fl = d[24];
      rm = d[1:0];
      cs = d[16:12];
      // the trap record keeps the matched pairs of the latest trap only
      if (|(en & cs)) begin
        ti = {25'h0, 1'b1, 1'b0, en & cs};
      end
      rd(`FPXM_OFF_ENABLES, view());
      rd(`FPXM_OFF_STATUS, st_view());
      rd(`FPXM_OFF_TRAPINFO, ti);
    end
    // strobes with the clock enable low are ignored
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(`FPXM_OFF_ENABLES, ~view());
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rd(`FPXM_OFF_ENABLES, view());
    // a reset in mid-run parks every field and the trap record at zero
    @(posedge ref_clk);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    rst_n <= 1'b1;
    en = 5'h00;
    fl = 1'b0;
    rm = 2'h0;
    rd(`FPXM_OFF_ENABLES, view());
    rd(`FPXM_OFF_TRAPINFO, 32'h0000_0000);
    final_report();
  end
endmodule : tb
